// [src/i2c_slv_pkg.sv]
// Shared constants and types for the serial port slave and its bus master
package i2c_slv_pkg;
	localparam int SYS_PERIOD_NS = 25;          // System clock period
	localparam int SCL_PERIOD_NS = 10000;       // Master serial clock period, 100 kHz
	// Quarter of a serial clock period in system cycles, rounded down
	localparam int QUARTER_CYCLES = SCL_PERIOD_NS / (4 * SYS_PERIOD_NS);
	localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e; // Fixed head of a 10-bit high byte
	localparam logic [7:0] ADDR_RESET     = 8'h00; // Slave address after reset
	localparam logic [7:0] BUF_RESET      = 8'h00; // Transfer buffer after reset
	localparam logic [3:0] BITS_PER_BYTE  = 4'h8;  // Data bits before the ack slot
	localparam logic [3:0] CNT_RESET      = 4'h0;  // Bit counter start
	localparam logic [1:0] SYNC_RESET     = 2'h3;  // Idle bus reads high
	// Slave byte phases
	typedef enum logic [2:0] {
		S_IDLE  = 3'h0,
		S_ADDR1 = 3'h1,
		S_ADDR2 = 3'h2,
		S_RX    = 3'h3,
		S_TX    = 3'h4
	} slv_state_t;
	// Master commands
	typedef enum logic [1:0] {
		CMD_START = 2'h0,
		CMD_WRITE = 2'h1,
		CMD_READ  = 2'h2,
		CMD_STOP  = 2'h3
	} cmd_t;
	// Master sequencer states
	typedef enum logic [1:0] {
		M_IDLE  = 2'h0,
		M_START = 2'h1,
		M_BIT   = 2'h2,
		M_STOP  = 2'h3
	} mst_state_t;
endpackage : i2c_slv_pkg

// [src/i2c_link_if.sv]
// Two-wire open-drain link joining the slave end and the master end
`timescale 1ns/100ps
interface i2c_link_if;
	logic devSclOut;    // Slave clock drive value
	logic devSclOeN;    // Slave clock enable, low drives
	logic devSdaOut;    // Slave data drive value
	logic devSdaOeN;    // Slave data enable, low drives
	logic hostSclOut;   // Master clock drive value
	logic hostSclOeN;   // Master clock enable, low drives
	logic hostSdaOut;   // Master data drive value
	logic hostSdaOeN;   // Master data enable, low drives
	logic sclLine;      // Resolved clock wire, pulled up
	logic sdaLine;      // Resolved data wire, pulled up
	// Wired-AND of both ends with a pull-up
	assign sclLine = (devSclOeN | devSclOut) & (hostSclOeN | hostSclOut);
	assign sdaLine = (devSdaOeN | devSdaOut) & (hostSdaOeN | hostSdaOut);
	modport dev (input sclLine, input sdaLine, output devSclOut, output devSclOeN,
		output devSdaOut, output devSdaOeN);
	modport host (input sclLine, input sdaLine, output hostSclOut, output hostSclOeN,
		output hostSdaOut, output hostSdaOeN);
endinterface : i2c_link_if

// [src/i2c_slave_dev.sv]
// Serial port slave: read transmission, address hold and 10-bit addressing
// Function
// (RQ1) Read address match: flag, buffer, ack
// (RQ2) After read ack clear release, hold clock
// (RQ3) Buffer write also loads shift register
// (RQ4) Transmit bits change on clock falling edges
// (RQ5) Sample master ack on ninth rising edge
// (RQ6) Master not-ack ends transfer, go idle
// (RQ7) Software loads next byte then releases clock
// (RQ8) Interrupt flag set on ninth falling edge
// (RQ9) Enabled collision while sending sets flag, idles
// (RQ10) Start sets start flag, optional interrupt
// (RQ11) Master not-ack: no stretch, still interrupt
// (RQ12) Address hold: clear release, stretch, interrupt
// (RQ13) Hold: software chooses ack value to drive
// (RQ14) Read ack clears release and interrupts
// (RQ15) Buffer load sets full flag, after ack
// (RQ16) Master not-acks last read byte
// (RQ17) 10-bit high byte write sets update flag
// (RQ18) Address write releases clock, clears update
// (RQ19) Address update only after ninth falling edge
// (RQ20) Low byte mismatch: flags set, release unchanged
// (RQ21) Stretch enable: stretch after each data byte
// (RQ22) Address hold sets ack-time flag on eighth
// (RQ23) 10-bit head is 11110 plus address bits 2:1
`timescale 1ns/100ps
module i2c_slave_dev (
	input  wire logic       sys_clk,                       // System clock
	input  wire logic       rst,                           // Synchronous reset
	i2c_link_if.dev         link,                          // Bus pins
	input  wire logic       tenBitMode,                    // 10-bit addressing
	input  wire logic       address_hold_enable,           // Stretch before address ack
	input  wire logic       clock_stretch_enable,          // Stretch after data bytes
	input  wire logic       startIntEnable,                // Interrupt on start
	input  wire logic       slave_collision_detect_enable, // Watch for collisions
	input  wire logic       ack_value_select,              // Ack value during a hold
	input  wire logic       bufWrite,                      // Software writes buffer
	input  wire logic [7:0] bufWriteData,                  // Data for buffer
	input  wire logic       bufRead,                       // Software reads buffer
	input  wire logic       addrWrite,                     // Software writes address
	input  wire logic [7:0] addrWriteData,                 // New slave address
	input  wire logic       releaseSet,                    // Software sets release bit
	input  wire logic       intClear,                      // Software clears interrupt
	input  wire logic       collisionClear,                // Software clears collision
	output logic      [7:0] transfer_buffer,               // Buffer contents
	output logic      [7:0] slave_address_reg,             // Address register
	output logic            port_interrupt_flag,           // Sticky interrupt
	output logic            bus_collision_flag,            // Sticky collision
	output logic            buffer_full_flag,              // Buffer holds a byte
	output logic            readWriteFlag,                 // Last address was a read
	output logic            startSeen,                     // Start seen, cleared by stop
	output logic            update_address_flag,           // Address needs update
	output logic            ack_received_bit,              // Last master ack, high = not-ack
	output logic            ack_time_flag,                 // In ack time of a held address
	output logic            clock_release_bit              // Clock released when high
);
	logic [1:0]               sclSync;   // Clock synchroniser
	logic [1:0]               sdaSync;   // Data synchroniser
	logic                     sclPrev;   // Clock one cycle back
	logic                     sdaPrev;   // Data one cycle back
	i2c_slv_pkg::slv_state_t  state;     // Byte phase
	logic [3:0]               bitCnt;    // Bits taken in this byte
	logic                     ackPhase;  // Between eighth and ninth falling edge
	logic                     ackBit;    // Ack to drive, high = not-ack
	logic                     tenMatched;// Full 10-bit write match held
	logic [7:0]               serial_shift_reg; // Incoming bits
	logic [7:0]               txShift;   // Outgoing bits
	logic                     sclHold;   // Holding the clock low

	// Edge and condition detection on synchronised pins
	wire sclRise   = sclSync[1] & ~sclPrev;
	wire sclFall   = ~sclSync[1] & sclPrev;
	wire startCond = sclSync[1] & sclPrev & ~sdaSync[1] & sdaPrev;
	wire stopCond  = sclSync[1] & sclPrev & sdaSync[1] & ~sdaPrev;
	wire active    = state != i2c_slv_pkg::S_IDLE;
	wire eighthFall = sclFall & ~ackPhase & active & (bitCnt == i2c_slv_pkg::BITS_PER_BYTE);
	wire ninthRise = sclRise & ackPhase & active;
	wire ninthFall = sclFall & ackPhase & active;
	// Address compare for first byte
	wire [6:0] hiPattern = tenBitMode ? {i2c_slv_pkg::TEN_BIT_PREFIX, slave_address_reg[2:1]} // RQ23
		: slave_address_reg[7:1];
	wire readReq   = serial_shift_reg[0];
	// A 10-bit read is only accepted after a full write match
	wire addr1Ok   = (serial_shift_reg[7:1] == hiPattern) & (~tenBitMode | ~readReq | tenMatched);
	wire addr2Ok   = serial_shift_reg == slave_address_reg;
	wire holdAddr  = address_hold_enable & (state == i2c_slv_pkg::S_ADDR1);
	// Value the slave answers with in the ack slot
	wire slaveNack = ack_time_flag ? ack_value_select : ackBit; // RQ13
	wire collide   = sclRise & (state == i2c_slv_pkg::S_TX) & ~ackPhase & txShift[7]
		& ~sdaSync[1] & slave_collision_detect_enable;
	// Address update always stretches; release bit only inside a transfer
	wire holdWanted = update_address_flag | (~clock_release_bit & active);

	// Two-flop pin synchronisers, first stage read only by the second
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sclSync <= i2c_slv_pkg::SYNC_RESET;
			sdaSync <= i2c_slv_pkg::SYNC_RESET;
			sclPrev <= 1'b1;
			sdaPrev <= 1'b1;
		end else begin
			sclSync <= {sclSync[0], link.sclLine};
			sdaSync <= {sdaSync[0], link.sdaLine};
			sclPrev <= sclSync[1];
			sdaPrev <= sdaSync[1];
		end
	end

	// Byte sequencer
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state    <= i2c_slv_pkg::S_IDLE;
			bitCnt   <= i2c_slv_pkg::CNT_RESET;
			ackPhase <= 1'b0;
			ackBit   <= 1'b1;
			serial_shift_reg <= i2c_slv_pkg::BUF_RESET;
		end else if (startCond) begin
			// Start or restart: next byte is an address
			state    <= i2c_slv_pkg::S_ADDR1;
			bitCnt   <= i2c_slv_pkg::CNT_RESET;
			ackPhase <= 1'b0;
		end else if (stopCond || collide) begin
			state    <= i2c_slv_pkg::S_IDLE; // RQ9
			ackPhase <= 1'b0;
		end else if (sclRise && active && !ackPhase && bitCnt != i2c_slv_pkg::BITS_PER_BYTE) begin
			serial_shift_reg <= {serial_shift_reg[6:0], sdaSync[1]};
			bitCnt           <= bitCnt + 4'h1;
		end else if (eighthFall) begin
			ackPhase <= 1'b1;
			unique case (state)
				i2c_slv_pkg::S_ADDR1: begin
					ackBit <= 1'b0; // RQ1
					if (!addr1Ok) begin
						// Not ours: go quiet until the next start
						state    <= i2c_slv_pkg::S_IDLE;
						ackPhase <= 1'b0;
					end
				end
				i2c_slv_pkg::S_ADDR2: ackBit <= ~addr2Ok;
				i2c_slv_pkg::S_RX:    ackBit <= buffer_full_flag; // Overflow refuses the byte
				i2c_slv_pkg::S_TX:    ackBit <= 1'b1;             // Release for master ack
				default:              ackBit <= 1'b1;
			endcase
		end else if (ninthFall) begin
			ackPhase <= 1'b0;
			bitCnt   <= i2c_slv_pkg::CNT_RESET;
			unique case (state)
				i2c_slv_pkg::S_ADDR1: begin
					if (slaveNack)
						state <= i2c_slv_pkg::S_IDLE;
					else if (readReq)
						state <= i2c_slv_pkg::S_TX;
					else if (tenBitMode)
						state <= i2c_slv_pkg::S_ADDR2; // RQ17
					else
						state <= i2c_slv_pkg::S_RX;
				end
				i2c_slv_pkg::S_ADDR2: state <= slaveNack ? i2c_slv_pkg::S_IDLE : i2c_slv_pkg::S_RX;
				i2c_slv_pkg::S_RX:    state <= slaveNack ? i2c_slv_pkg::S_IDLE : i2c_slv_pkg::S_RX;
				i2c_slv_pkg::S_TX:    state <= ack_received_bit ? i2c_slv_pkg::S_IDLE // RQ6
					: i2c_slv_pkg::S_TX;
				default:              state <= i2c_slv_pkg::S_IDLE;
			endcase
		end
	end

	// 10-bit full match memory, dropped at stop
	always_ff @(posedge sys_clk) begin
		if (rst || stopCond)
			tenMatched <= 1'b0;
		else if (ninthFall && state == i2c_slv_pkg::S_ADDR2 && !slaveNack)
			tenMatched <= 1'b1;
	end

	// Outgoing shifter: software load, then shift after the falling edges of bits 1 to 7
	always_ff @(posedge sys_clk) begin
		if (rst)
			txShift <= i2c_slv_pkg::BUF_RESET;
		else if (bufWrite)
			txShift <= bufWriteData; // RQ3
		else if (sclFall && state == i2c_slv_pkg::S_TX && !ackPhase && bitCnt != i2c_slv_pkg::CNT_RESET
			&& bitCnt != i2c_slv_pkg::BITS_PER_BYTE)
			txShift <= {txShift[6:0], 1'b1}; // RQ4
	end

	// Transfer buffer and full flag; hardware set wins over a read
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			transfer_buffer  <= i2c_slv_pkg::BUF_RESET;
			buffer_full_flag <= 1'b0;
		end else begin
			if (bufRead)
				buffer_full_flag <= 1'b0;
			if (ninthFall && state == i2c_slv_pkg::S_TX)
				buffer_full_flag <= 1'b0; // Byte has left
			if (eighthFall && ((state == i2c_slv_pkg::S_ADDR1 && addr1Ok) // RQ1
				|| (state == i2c_slv_pkg::S_ADDR2 && addr2Ok) // RQ20
				|| (state == i2c_slv_pkg::S_RX && !buffer_full_flag))) begin
				transfer_buffer  <= serial_shift_reg;
				buffer_full_flag <= 1'b1;
			end
			if (bufWrite) begin
				transfer_buffer  <= bufWriteData;
				buffer_full_flag <= 1'b1; // RQ15
			end
		end
	end

	// Interrupt flag; set wins over the software clear
	always_ff @(posedge sys_clk) begin
		if (rst)
			port_interrupt_flag <= 1'b0;
		else begin
			if (intClear)
				port_interrupt_flag <= 1'b0;
			if (startCond && startIntEnable)
				port_interrupt_flag <= 1'b1; // RQ10
			if (eighthFall && holdAddr && addr1Ok)
				port_interrupt_flag <= 1'b1; // RQ12
			// Every byte except one the slave refused; low byte mismatch still counts
			if (ninthFall && (state == i2c_slv_pkg::S_TX || state == i2c_slv_pkg::S_ADDR2 || !slaveNack))
				port_interrupt_flag <= 1'b1; // RQ8 RQ11 RQ14 RQ20
		end
	end

	// Clock release bit: hardware clears, software set last
	always_ff @(posedge sys_clk) begin
		if (rst)
			clock_release_bit <= 1'b1;
		else begin
			if (eighthFall && holdAddr && addr1Ok)
				clock_release_bit <= 1'b0; // RQ12
			if (ninthFall && state == i2c_slv_pkg::S_ADDR1 && readReq && !slaveNack)
				clock_release_bit <= 1'b0; // RQ2 RQ14
			if (ninthFall && state == i2c_slv_pkg::S_TX && !ack_received_bit)
				clock_release_bit <= 1'b0; // RQ7
			if (ninthFall && state == i2c_slv_pkg::S_RX && clock_stretch_enable && !slaveNack)
				clock_release_bit <= 1'b0; // RQ21
			if (releaseSet)
				clock_release_bit <= 1'b1;
		end
	end

	// Address register and update-address flag
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			slave_address_reg   <= i2c_slv_pkg::ADDR_RESET;
			update_address_flag <= 1'b0;
		end else begin
			// Software owns timing: write only after the ninth falling edge
			if (addrWrite) begin
				slave_address_reg   <= addrWriteData; // RQ19
				update_address_flag <= 1'b0;          // RQ18
			end
			if (ninthFall && ((state == i2c_slv_pkg::S_ADDR1 && tenBitMode && !readReq && !slaveNack)
				|| state == i2c_slv_pkg::S_ADDR2))
				update_address_flag <= 1'b1; // RQ17 RQ20
		end
	end

	// Status flags from bus events
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			readWriteFlag    <= 1'b0;
			startSeen        <= 1'b0;
			ack_received_bit <= 1'b0;
			ack_time_flag    <= 1'b0;
		end else begin
			if (startCond)
				startSeen <= 1'b1; // RQ10
			else if (stopCond)
				startSeen <= 1'b0;
			if (eighthFall && state == i2c_slv_pkg::S_ADDR1 && addr1Ok)
				readWriteFlag <= readReq; // RQ1
			if (ninthRise && state == i2c_slv_pkg::S_TX)
				ack_received_bit <= sdaSync[1]; // RQ5
			if (eighthFall && holdAddr && addr1Ok)
				ack_time_flag <= 1'b1; // RQ22
			else if (ninthFall || startCond || stopCond)
				ack_time_flag <= 1'b0;
		end
	end

	// Collision flag; set wins over clear
	always_ff @(posedge sys_clk) begin
		if (rst)
			bus_collision_flag <= 1'b0;
		else begin
			if (collisionClear)
				bus_collision_flag <= 1'b0;
			if (collide)
				bus_collision_flag <= 1'b1; // RQ9
		end
	end

	// Clock hold starts only once the line is already low, so high time is never cut
	always_ff @(posedge sys_clk) begin
		if (rst)
			sclHold <= 1'b0;
		else if (!holdWanted)
			sclHold <= 1'b0; // RQ18
		else if (!sclSync[1])
			sclHold <= 1'b1; // RQ2 RQ12 RQ21
	end

	// Pin drivers, open drain
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			link.devSclOut <= 1'b0;
			link.devSdaOut <= 1'b0;
			link.devSclOeN <= 1'b1;
			link.devSdaOeN <= 1'b1;
		end else begin
			link.devSclOut <= 1'b0;
			link.devSdaOut <= 1'b0;
			link.devSclOeN <= ~sclHold;
			// Ack slot: driven only once the clock is released
			if (ackPhase && state != i2c_slv_pkg::S_TX)
				link.devSdaOeN <= ~(clock_release_bit & ~slaveNack); // RQ1 RQ13
			else
				link.devSdaOeN <= ~(state == i2c_slv_pkg::S_TX & ~ackPhase & ~txShift[7]); // RQ4
		end
	end
endmodule : i2c_slave_dev

// [src/i2c_master_host.sv]
// Bus master end: start, byte write, byte read and stop on the two-wire link
`timescale 1ns/100ps
module i2c_master_host #(
	parameter int QUARTER = i2c_slv_pkg::QUARTER_CYCLES // System cycles per quarter bit
) (
	input  wire logic             sys_clk,  // System clock
	input  wire logic             rst,      // Synchronous reset
	i2c_link_if.host              link,     // Bus pins
	input  wire logic             cmdValid, // Command offered
	input  wire i2c_slv_pkg::cmd_t cmdType, // Command kind
	input  wire logic       [7:0] cmdData,  // Byte to write
	input  wire logic             cmdNack,  // Read: answer not-ack
	output logic                  cmdReady, // Idle, command taken when valid
	output logic                  cmdDone,  // One-cycle end of command
	output logic            [7:0] rdData,   // Byte read or last shifted
	output logic                  ackSeen   // Slave answer, high = not-ack
);
	logic [1:0]               sclSync;  // Clock synchroniser
	logic [1:0]               sdaSync;  // Data synchroniser
	logic [15:0]              divCnt;   // Quarter-bit divider
	logic                     tick;     // Quarter-bit enable pulse
	i2c_slv_pkg::mst_state_t  state;    // Sequencer state
	i2c_slv_pkg::cmd_t        op;       // Command in progress
	logic [1:0]               phase;    // Quarter within a bit
	logic [3:0]               bitIdx;   // Bit within a byte
	logic [7:0]               shift;    // Byte shifter
	logic                     nackOut;  // Ack to send on a read

	// Two-flop pin synchronisers
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sclSync <= i2c_slv_pkg::SYNC_RESET;
			sdaSync <= i2c_slv_pkg::SYNC_RESET;
		end else begin
			sclSync <= {sclSync[0], link.sclLine};
			sdaSync <= {sdaSync[0], link.sdaLine};
		end
	end

	// Divider giving one enable per quarter bit
	always_ff @(posedge sys_clk) begin
		if (rst || divCnt == 16'(QUARTER - 1)) begin
			divCnt <= 16'h0000;
			tick   <= ~rst;
		end else begin
			divCnt <= divCnt + 16'h0001;
			tick   <= 1'b0;
		end
	end

	// Sequencer; phase 2 waits for the clock to read high, honouring slave stretch
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state           <= i2c_slv_pkg::M_IDLE;
			op              <= i2c_slv_pkg::CMD_START;
			phase           <= 2'h0;
			bitIdx          <= i2c_slv_pkg::CNT_RESET;
			shift           <= i2c_slv_pkg::BUF_RESET;
			nackOut         <= 1'b1;
			cmdReady        <= 1'b1;
			cmdDone         <= 1'b0;
			rdData          <= i2c_slv_pkg::BUF_RESET;
			ackSeen         <= 1'b1;
			link.hostSclOeN <= 1'b1;
			link.hostSdaOeN <= 1'b1;
			link.hostSclOut <= 1'b0;
			link.hostSdaOut <= 1'b0;
		end else begin
			cmdDone <= 1'b0;
			if (state == i2c_slv_pkg::M_IDLE) begin
				if (cmdValid) begin
					// Command taken; bytes share one bit engine
					op       <= cmdType;
					shift    <= cmdData;
					nackOut  <= cmdNack;
					phase    <= 2'h0;
					bitIdx   <= i2c_slv_pkg::CNT_RESET;
					cmdReady <= 1'b0;
					unique case (cmdType)
						i2c_slv_pkg::CMD_START: state <= i2c_slv_pkg::M_START;
						i2c_slv_pkg::CMD_STOP:  state <= i2c_slv_pkg::M_STOP;
						default:                state <= i2c_slv_pkg::M_BIT;
					endcase
				end
			end else if (tick && !(phase == 2'h2 && !sclSync[1])) begin
				phase <= phase + 2'h1;
				unique case (phase)
					2'h0: begin
						// Clock low: set up data
						if (state == i2c_slv_pkg::M_START)
							link.hostSdaOeN <= 1'b1;
						else if (state == i2c_slv_pkg::M_STOP)
							link.hostSdaOeN <= 1'b0;
						else if (bitIdx == i2c_slv_pkg::BITS_PER_BYTE)
							// Ack slot: master reading answers, last byte not-acked
							link.hostSdaOeN <= (op == i2c_slv_pkg::CMD_READ) ? nackOut : 1'b1; // RQ16
						else
							link.hostSdaOeN <= (op == i2c_slv_pkg::CMD_READ) ? 1'b1 : shift[7];
					end
					2'h1: link.hostSclOeN <= 1'b1;
					2'h2: begin
						// Clock is high: start edge or sample
						if (state == i2c_slv_pkg::M_START)
							link.hostSdaOeN <= 1'b0;
						else if (state == i2c_slv_pkg::M_BIT) begin
							if (bitIdx == i2c_slv_pkg::BITS_PER_BYTE)
								ackSeen <= sdaSync[1];
							else
								shift <= {shift[6:0], sdaSync[1]};
						end
					end
					2'h3: begin
						if (state == i2c_slv_pkg::M_STOP)
							link.hostSdaOeN <= 1'b1;
						else
							link.hostSclOeN <= 1'b0;
						if (state == i2c_slv_pkg::M_BIT && bitIdx != i2c_slv_pkg::BITS_PER_BYTE)
							bitIdx <= bitIdx + 4'h1;
						else begin
							state    <= i2c_slv_pkg::M_IDLE;
							cmdReady <= 1'b1;
							cmdDone  <= 1'b1;
							rdData   <= shift;
						end
					end
				endcase
			end
		end
	end
endmodule : i2c_master_host

// [tb/i2c_slave_transmit_and_10bit_address_asserts.sv]
// Link checker: slave drive timing on the two-wire bus
`timescale 1ns/100ps
module i2c_slave_transmit_and_10bit_address_asserts (
	input wire logic sys_clk,   // System clock
	input wire logic rst,       // Sync reset
	input wire logic devSclOut, // Slave clock value
	input wire logic devSclOeN, // Slave clock enable
	input wire logic devSdaOut, // Slave data value
	input wire logic devSdaOeN, // Slave data enable
	input wire logic sclLine,   // Clock wire
	input wire logic sdaLine    // Data wire
);
	logic       pScl;  // Clock wire last cycle
	logic       pSda;  // Data wire last cycle
	logic [3:0] fall;  // Falls since start, 8 is ack slot
	logic       start; // Start condition
	logic       stop;  // Stop condition
	assign start = pScl & sclLine & pSda & ~sdaLine;
	assign stop = pScl & sclLine & ~pSda & sdaLine;
	// Wire history, idle bus reads high
	always_ff @(posedge sys_clk) begin
		pScl <= rst | sclLine;
		pSda <= rst | sdaLine;
	end
	// Bit slot; 15 marks the fall that closes a start
	always_ff @(posedge sys_clk) begin
		if (rst || start) begin
			fall <= 4'hf;
		end else if (pScl && !sclLine) begin
			fall <= (fall == 4'h8 || fall == 4'hf) ? 4'h0 : fall + 4'h1;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	property p_open_drain; devSclOut == 1'b0 && devSdaOut == 1'b0; endproperty
	a_open_drain: assert property (p_open_drain) else $error("slave drives high");
	property p_sda_low; $changed(devSdaOeN) |-> !sclLine; endproperty
	a_sda_low: assert property (p_sda_low) else $error("data moved in clock high");
	property p_sda_high; $rose(sclLine) |-> $stable(devSdaOeN) [*4]; endproperty
	a_sda_high: assert property (p_sda_high) else $error("data unstable in high");
	property p_hold_sync; $fell(devSclOeN) |-> !$past(sclLine); endproperty
	a_hold_sync: assert property (p_hold_sync) else $error("clock grabbed while high");
	property p_hold_slot; $fell(devSclOeN) |-> (fall == 4'h0 || fall == 4'h8); endproperty
	a_hold_slot: assert property (p_hold_slot) else $error("stretch off byte edge");
	property p_start_quiet; start |-> devSdaOeN [*3]; endproperty
	a_start_quiet: assert property (p_start_quiet) else $error("data driven at start");
	property p_release_gap; $rose(devSclOeN) |=> devSclOeN [*8]; endproperty
	a_release_gap: assert property (p_release_gap) else $error("clock grabbed again");
	property p_stop_idle; stop |-> (devSdaOeN && devSclOeN) [*8]; endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("slave busy after stop");
endmodule : i2c_slave_transmit_and_10bit_address_asserts

// [tb/tb_i2c_slave_transmit_and_10bit_address.sv]
// Bench: master end reads and writes the slave end
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; $display("mismatch %0t bad", $time); end end
module tb_i2c_slave_transmit_and_10bit_address;
	localparam int     QUARTER = 6;     // Short bit keeps run brief
	logic              sys_clk = 1'b0;  // System clock
	logic              rst = 1'b1;      // Sync reset
	logic [5:0]        cfg = 6'h02;     // tenBit hold stretch startInt collide ackValue
	logic [5:0]        sw = 6'h00;      // Software strobes, bufWrite at bit 0
	logic [7:0]        swData = 8'h00;  // Software data
	logic              cmdValid = 1'b0; // Master strobe
	i2c_slv_pkg::cmd_t cmdType;         // Master command
	logic [7:0]        cmdData = 8'h00; // Master byte
	logic              cmdNack = 1'b0;  // Master ack answer
	logic              cmdReady, cmdDone, ackSeen, irq, bcol, bfull, rw, sseen, upd, ackr, ackt, rel;
	logic [7:0]        rdData, tbuf, sadr, d;
	logic [10:0]       ent;             // ackCare dataCare ack data
	logic [10:0]       expq[$];         // Noted master results
	int                mismatches = 0, samples_checked = 0, cycles = 0;
	i2c_link_if i2c_link_if_i ();
	i2c_slave_dev i2c_slave_dev_i (.sys_clk(sys_clk), .rst(rst), .link(i2c_link_if_i.dev), .tenBitMode(cfg[5]),
		.address_hold_enable(cfg[4]), .clock_stretch_enable(cfg[3]), .startIntEnable(cfg[2]),
		.slave_collision_detect_enable(cfg[1]), .ack_value_select(cfg[0]), .bufWrite(sw[0]), .bufWriteData(swData),
		.bufRead(sw[1]), .addrWrite(sw[2]), .addrWriteData(swData), .releaseSet(sw[3]), .intClear(sw[4]),
		.collisionClear(sw[5]), .transfer_buffer(tbuf), .slave_address_reg(sadr), .port_interrupt_flag(irq),
		.bus_collision_flag(bcol), .buffer_full_flag(bfull), .readWriteFlag(rw), .startSeen(sseen),
		.update_address_flag(upd), .ack_received_bit(ackr), .ack_time_flag(ackt), .clock_release_bit(rel));
	i2c_master_host #(.QUARTER(QUARTER)) i2c_master_host_i (.sys_clk(sys_clk), .rst(rst), .link(i2c_link_if_i.host),
		.cmdValid(cmdValid), .cmdType(cmdType), .cmdData(cmdData), .cmdNack(cmdNack), .cmdReady(cmdReady),
		.cmdDone(cmdDone), .rdData(rdData), .ackSeen(ackSeen));
	i2c_slave_transmit_and_10bit_address_asserts i2c_slave_transmit_and_10bit_address_asserts_i (.sys_clk(sys_clk),
		.rst(rst), .devSclOut(i2c_link_if_i.devSclOut), .devSclOeN(i2c_link_if_i.devSclOeN),
		.devSdaOut(i2c_link_if_i.devSdaOut), .devSdaOeN(i2c_link_if_i.devSdaOeN), .sclLine(i2c_link_if_i.sclLine),
		.sdaLine(i2c_link_if_i.sdaLine));
	// 40 MHz clock
	initial begin
		forever #12.5 sys_clk = ~sys_clk;
	end
	// Verdict and end of run
	task automatic final_report();
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : final_report
	// One-cycle software strobe, then let flags land
	task automatic pulse(input int idx, input logic [7:0] val);
		@(posedge sys_clk);
		sw[idx] <= 1'b1;
		swData <= val;
		@(posedge sys_clk);
		sw[idx] <= 1'b0;
		#1;
	endtask : pulse
	// Master command 0 start 1 write 2 read 3 stop; result noted first
	task automatic mcmd(input logic [1:0] t, input logic [7:0] v, input logic n, input logic [10:0] e);
		expq.push_back(e);
		@(posedge sys_clk);
		cmdValid <= 1'b1;
		cmdType <= i2c_slv_pkg::cmd_t'(t);
		cmdData <= v;
		cmdNack <= n;
		@(posedge sys_clk);
		cmdValid <= 1'b0;
		while (cmdDone !== 1'b1) @(posedge sys_clk);
	endtask : mcmd
	// Wait for interrupt, then settle
	task automatic waitIf();
		while (irq !== 1'b1) @(posedge sys_clk);
		repeat (2) @(posedge sys_clk);
	endtask : waitIf
	// Result watcher compares with the oldest note
	always @(posedge sys_clk) begin
		if (cmdDone === 1'b1 && expq.size() > 0) begin
			ent = expq.pop_front();
			if (ent[10]) `CHK(ackSeen, ent[8])
			if (ent[9]) `CHK(rdData, ent[7:0])
		end
	end
	// Hang guard
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 40000) begin
			mismatches++;
			final_report();
		end
	end
	// Main sequence
	initial begin
		void'($urandom(16000));
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		pulse(2, 8'h54);
		// Plain read: ack then not-ack
		mcmd(2'h0, 8'h00, 1'b0, 11'h000);
		mcmd(2'h1, 8'h55, 1'b0, 11'h400);
		waitIf();
		`CHK(rw, 1'b1)
		`CHK(tbuf, 8'h55)
		`CHK(rel, 1'b0)
		pulse(1, 8'h00);
		pulse(4, 8'h00);
		for (int k = 0; k < 2; k++) begin
			d = 8'($urandom);
			pulse(0, d);
			`CHK(bfull, 1'b1)
			`CHK(tbuf, d)
			pulse(3, 8'h00);
			mcmd(2'h2, 8'h00, k[0], {2'b11, k[0], d});
			waitIf();
			`CHK(ackr, k[0])
			`CHK(rel, k[0])
			`CHK(bcol, 1'b0)
			pulse(4, 8'h00);
		end
		mcmd(2'h3, 8'h00, 1'b0, 11'h000);
		// Address hold with software not-ack
		@(posedge sys_clk);
		cfg <= 6'h17;
		mcmd(2'h0, 8'h00, 1'b0, 11'h000);
		`CHK(sseen, 1'b1)
		`CHK(irq, 1'b1)
		pulse(4, 8'h00);
		fork
			mcmd(2'h1, 8'h55, 1'b0, 11'h500);
			begin
				waitIf();
				`CHK(ackt, 1'b1)
				`CHK(rel, 1'b0)
				pulse(4, 8'h00);
				pulse(3, 8'h00);
			end
		join
		pulse(1, 8'h00);
		`CHK(irq, 1'b0)
		`CHK(ackt, 1'b0)
		mcmd(2'h3, 8'h00, 1'b0, 11'h000);
		// Ten-bit high match, low mismatch
		@(posedge sys_clk);
		cfg <= 6'h22;
		pulse(2, 8'h06);
		mcmd(2'h0, 8'h00, 1'b0, 11'h000);
		mcmd(2'h1, 8'hf6, 1'b0, 11'h400);
		waitIf();
		`CHK(upd, 1'b1)
		pulse(1, 8'h00);
		pulse(4, 8'h00);
		pulse(2, 8'ha5);
		`CHK(upd, 1'b0)
		`CHK(sadr, 8'ha5)
		mcmd(2'h1, 8'h5a, 1'b0, 11'h500);
		waitIf();
		`CHK(upd, 1'b1)
		`CHK(bfull, 1'b0)
		`CHK(rel, 1'b1)
		pulse(2, 8'h06);
		pulse(4, 8'h00);
		mcmd(2'h3, 8'h00, 1'b0, 11'h000);
		final_report();
	end
endmodule : tb_i2c_slave_transmit_and_10bit_address
